//--- test_watchdog_timer_unit.sv
// Testbench for the watchdog unit: APB tasks, ticked source runs, clear sequences.
// Assumes the sub clock ticks come from here; pclk/4 is used in the last two cases only.
module test_watchdog_timer_unit
    import wdtu_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, rerr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        cfg_wdt_enable, cfg_src_sub, cfg_sub_from_crystal, cfg_pair_clear;
    logic        low_speed_crystal_osc_tick, low_speed_rc_osc_tick, external_reset_pin_n;
    logic        single_clear_instr, first_pair_clear_instr, second_pair_clear_instr;
    logic        halt_instr, sleep_mode, first_idle_mode, idle_mode, idle_sysclk_keep_on;
    logic        device_reset, pc_sp_reset, timeout_flag, power_down_flag;
    int          err_count, check_count, n_dev, n_pc, d;

    wdtu_top u_dut (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .cfg_wdt_enable, .cfg_src_sub, .cfg_sub_from_crystal, .cfg_pair_clear,
        .low_speed_crystal_osc_tick, .low_speed_rc_osc_tick, .external_reset_pin_n,
        .single_clear_instr, .first_pair_clear_instr, .second_pair_clear_instr,
        .halt_instr, .sleep_mode, .first_idle_mode, .idle_mode, .idle_sysclk_keep_on,
        .device_reset, .pc_sp_reset, .timeout_flag, .power_down_flag, .irq
    );
    ////////////////////////////////////////////////////////////////////////
    // 40 MHz clock and counters of reset pulses
    initial begin
        pclk = 1'h0;
        forever #12.5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        if (device_reset === 1'h1) n_dev <= n_dev + 1;
        if (pc_sp_reset === 1'h1) n_pc <= n_pc + 1;
    end
    ////////////////////////////////////////////////////////////////////////
    // Compare, verdict, bus and stimulus tasks
    task check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task summarize;
        $display("mismatches %0d comparisons %0d", err_count, check_count);
        if (err_count == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Request held until pready seen high; read data taken at that edge
    task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
        int i;
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'h1;
        for (i = 0; i < 16; i++) begin
            @(posedge pclk);
            if (pready === 1'h1) break;
        end
        if (i == 16) begin
            err_count++;
            summarize();
        end
        rd = prdata;
        rerr = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(negedge pclk);
    endtask
    // One source tick every second cycle on the chosen oscillator
    task ticks(input logic rc, input int n);
        repeat (n) begin
            @(posedge pclk);
            low_speed_rc_osc_tick <= rc;
            low_speed_crystal_osc_tick <= !rc;
            @(posedge pclk);
            low_speed_rc_osc_tick <= 1'h0;
            low_speed_crystal_osc_tick <= 1'h0;
        end
    endtask
    // 0 single, 1 first, 2 second, 3 halt, 4 reset pin low
    task instr(input int k);
        @(posedge pclk);
        single_clear_instr <= (k == 0);
        first_pair_clear_instr <= (k == 1);
        second_pair_clear_instr <= (k == 2);
        halt_instr <= (k == 3);
        external_reset_pin_n <= (k != 4);
        @(posedge pclk);
        {single_clear_instr, first_pair_clear_instr, second_pair_clear_instr} <= 3'h0;
        halt_instr <= 1'h0;
        external_reset_pin_n <= 1'h1;
        @(negedge pclk);
    endtask
    // n-1 ticks must stay quiet, the n-th must give exactly one reset pulse
    task ovf_run(input logic rc, input int n, input logic pc);
        int d0, p0;
        d0 = n_dev;
        p0 = n_pc;
        ticks(rc, n - 1);
        repeat (4) @(posedge pclk);
        check(n_dev + n_pc - d0 - p0, 0);
        ticks(rc, 1);
        repeat (4) @(posedge pclk);
        check(pc ? n_pc - p0 : n_dev - d0, 1);
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        presetn = 1'h0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {cfg_wdt_enable, cfg_src_sub, cfg_sub_from_crystal, cfg_pair_clear} = 4'hE;
        {low_speed_crystal_osc_tick, low_speed_rc_osc_tick, external_reset_pin_n} = 3'h1;
        {single_clear_instr, first_pair_clear_instr, second_pair_clear_instr} = 3'h0;
        {halt_instr, sleep_mode, first_idle_mode, idle_mode} = 4'h0;
        repeat (6) @(posedge pclk);
        presetn <= 1'h1;
        apb(1'h0, WDTU_CONTROL_OFS, 32'h0);
        check(rd, 32'h7A);
        check(idle_sysclk_keep_on, 1'h0);
        apb(1'h0, 12'h020, 32'h0);
        check({rerr, rd[30:0]}, 32'h80000000);
        apb(1'h1, WDTU_CONTROL_OFS, 32'h85);
        check(idle_sysclk_keep_on, 1'h1);
        // Every period code up to 100; longer ones would dominate run time
        for (int c = 0; c < 5; c++) begin
            apb(1'h1, WDTU_CONTROL_OFS, 32'(c * 16 + 5));
            instr(0);
            ovf_run(1'h0, 256 << c, 1'h0);
            check(timeout_flag, 1'h1);
        end
        // Longest period, one tick every cycle to keep the run short
        apb(1'h1, WDTU_CONTROL_OFS, 32'h75);
        instr(0);
        d = n_dev;
        @(posedge pclk);
        low_speed_crystal_osc_tick <= 1'h1;
        repeat (32767) @(posedge pclk);
        low_speed_crystal_osc_tick <= 1'h0;
        repeat (4) @(posedge pclk);
        check(n_dev - d, 0);
        ticks(1'h0, 1);
        repeat (4) @(posedge pclk);
        check(n_dev - d, 1);
        // Event status, mask and write-one-to-clear; a mask bit of one passes
        apb(1'h0, WDTU_IRQ_ST_OFS, 32'h0);
        check(rd, 32'h1);
        apb(1'h1, WDTU_IRQ_MSK_OFS, 32'h0);
        check(irq, 1'h0);
        apb(1'h1, WDTU_IRQ_MSK_OFS, 32'h1);
        check(irq, 1'h1);
        apb(1'h1, WDTU_IRQ_ST_OFS, 32'h1);
        check(irq, 1'h0);
        apb(1'h1, WDTU_IRQ_MSK_OFS, 32'h0);
        check(irq, 1'h0);
        // RC source: crystal ticks must not count
        apb(1'h1, WDTU_CONTROL_OFS, 32'h05);
        @(posedge pclk);
        cfg_sub_from_crystal <= 1'h0;
        instr(0);
        d = n_dev;
        ticks(1'h0, 300);
        check(n_dev - d, 0);
        instr(0);
        ovf_run(1'h1, 256, 1'h0);
        @(posedge pclk);
        cfg_sub_from_crystal <= 1'h1;
        sleep_mode <= 1'h1;
        instr(0);
        ovf_run(1'h0, 256, 1'h1);
        check(timeout_flag, 1'h1);
        apb(1'h0, WDTU_IRQ_ST_OFS, 32'h0);
        check(rd[1], 1'h1);
        @(posedge pclk);
        sleep_mode <= 1'h0;
        cfg_pair_clear <= 1'h1;
        // Paired scheme: repeats are ignored, single clear too
        instr(4);
        ticks(1'h0, 200);
        instr(1);
        ticks(1'h0, 200);
        instr(1);
        instr(0);
        ovf_run(1'h0, 56, 1'h0);
        instr(4);
        instr(1);
        instr(2);
        ticks(1'h0, 200);
        instr(2);
        ovf_run(1'h0, 56, 1'h0);
        // Halt, then disable: clears become no-ops
        @(posedge pclk);
        cfg_pair_clear <= 1'h0;
        cfg_wdt_enable <= 1'h0;
        instr(3);
        check(power_down_flag, 1'h1);
        apb(1'h1, WDTU_CONTROL_OFS, 32'h0A);
        d = n_dev;
        ticks(1'h0, 300);
        check(n_dev - d, 0);
        apb(1'h0, WDTU_STATUS_OFS, 32'h0);
        check(rd[2], 1'h0);
        instr(0);
        check(power_down_flag, 1'h1);
        @(posedge pclk);
        cfg_wdt_enable <= 1'h1;
        instr(0);
        check(power_down_flag, 1'h0);
        ovf_run(1'h0, 256, 1'h0);
        // Halt and the reset pin both restart the count
        ticks(1'h0, 200);
        instr(3);
        ovf_run(1'h0, 256, 1'h0);
        ticks(1'h0, 200);
        instr(4);
        ovf_run(1'h0, 256, 1'h0);
        // pclk/4 source stands still in the first idle mode
        @(posedge pclk);
        cfg_src_sub <= 1'h0;
        first_idle_mode <= 1'h1;
        instr(0);
        d = n_dev;
        repeat (1100) @(posedge pclk);
        check(n_dev - d, 0);
        first_idle_mode <= 1'h0;
        repeat (1100) @(posedge pclk);
        check(n_dev - d, 1);
        // Sleep stops the pclk/4 source as well
        sleep_mode <= 1'h1;
        instr(0);
        d = n_pc;
        repeat (1100) @(posedge pclk);
        check(n_pc - d, 0);
        summarize();
    end
endmodule

//--- wdtu_divider.sv
// Watchdog divider: counts source enables, reports overflow at selected ratio.
// Assumes tick is a one-cycle enable on pclk; clear has priority over count.
module wdtu_divider
    import wdtu_pkg::*;
#(
    parameter int W = WDTU_DIV_W
) (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       tick,
    input  wire logic       clear,
    input  wire logic [2:0] period_sel,
    output logic            overflow
);
    typedef struct packed {
        logic [W-1:0] count;
        logic         ovf;
    } wdtu_div_t;

    wdtu_div_t st;
    wdtu_div_t next_st;
    logic [W-1:0] last;

    ////////////////////////////////////////////////////////////////////////////
    // Terminal value is ratio minus one, so ratio ticks reach overflow
    always_comb begin
        last = W'((1 << (WDTU_PER_BASE + int'(period_sel))) - 1);
        next_st = st;
        next_st.ovf = 1'b0;
        if (clear) begin
            next_st.count = '0;
        end else if (tick) begin
            if (st.count >= last) begin
                next_st.count = '0;
                next_st.ovf = 1'b1;
            end else begin
                next_st.count = st.count + 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign overflow = st.ovf;
endmodule

//--- wdtu_pkg.sv
// Package for the watchdog timer unit: register map, field layout, reset values.
// Assumes a 32-bit APB slave bus on pclk; all offsets are byte addresses.
package wdtu_pkg;
    // Register byte offsets
    localparam logic [11:0] WDTU_CONTROL_OFS = 12'h000;
    localparam logic [11:0] WDTU_STATUS_OFS  = 12'h004;
    localparam logic [11:0] WDTU_IRQ_ST_OFS  = 12'h008;
    localparam logic [11:0] WDTU_IRQ_MSK_OFS = 12'h00C;
    localparam logic [11:0] WDTU_CMD_OFS     = 12'h010;

    // Control register layout and reset
    localparam int          WDTU_IDLE_BIT    = 7;
    localparam int          WDTU_PER_HI      = 6;
    localparam int          WDTU_PER_LO      = 4;
    localparam int          WDTU_KEY_HI      = 3;
    localparam logic [7:0]  WDTU_CONTROL_RST = 8'h7A;
    localparam logic [3:0]  WDTU_KEY_DISABLE = 4'hA;

    // Status bits
    localparam int          WDTU_ST_TO       = 0;
    localparam int          WDTU_ST_PDF      = 1;
    localparam int          WDTU_ST_EN       = 2;

    // Command register bits (write one to issue)
    localparam int          WDTU_CMD_SINGLE  = 0;
    localparam int          WDTU_CMD_FIRST   = 1;
    localparam int          WDTU_CMD_SECOND  = 2;
    localparam int          WDTU_CMD_HALT    = 3;

    // Event bits for interrupts
    localparam int          WDTU_EV_NORMAL   = 0;
    localparam int          WDTU_EV_SLEEP    = 1;
    localparam int          WDTU_NEV         = 2;

    // Divider sizing
    localparam int          WDTU_DIV_W       = 15;
    localparam int          WDTU_PER_BASE    = 8;
    localparam logic [1:0]  WDTU_SYS_DIV     = 2'h3;

    typedef enum logic {WDTU_EXPECT_FIRST, WDTU_EXPECT_SECOND} wdtu_pair_t;
endpackage

//--- wdtu_top.sv
// Watchdog timer unit top: APB registers, source select, clear logic, resets.
// Assumes configuration options are static inputs and all pins sync to pclk.
module wdtu_top
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        cfg_wdt_enable,
    input  wire logic        cfg_src_sub,
    input  wire logic        cfg_sub_from_crystal,
    input  wire logic        cfg_pair_clear,
    input  wire logic        low_speed_crystal_osc_tick,
    input  wire logic        low_speed_rc_osc_tick,
    input  wire logic        external_reset_pin_n,
    input  wire logic        single_clear_instr,
    input  wire logic        first_pair_clear_instr,
    input  wire logic        second_pair_clear_instr,
    input  wire logic        halt_instr,
    input  wire logic        sleep_mode,
    input  wire logic        first_idle_mode,
    input  wire logic        idle_mode,
    output logic             idle_sysclk_keep_on,
    output logic             device_reset,
    output logic             pc_sp_reset,
    output logic             timeout_flag,
    output logic             power_down_flag,
    output logic             irq
);
    import wdtu_pkg::*;

    typedef struct packed {
        logic [7:0]          control;
        logic                to_flag;
        logic                pd_flag;
        wdtu_pair_t          pair;
        logic [1:0]          sysdiv;
        logic                dev_rst;
        logic                pcsp_rst;
        logic [WDTU_NEV-1:0] irq_st;
        logic [WDTU_NEV-1:0] irq_msk;
        logic [31:0]         rdata;
    } wdtu_state_t;

    wdtu_state_t st;
    wdtu_state_t next_st;

    logic                enabled;
    logic                sub_tick;
    logic                src_tick;
    logic                sys_stopped;
    logic                any_clear;
    logic                pair_ok;
    logic                div_clear;
    logic                overflow;
    logic                wr_acc;
    logic                rd_acc;
    logic                sw_single;
    logic                sw_first;
    logic                sw_second;
    logic                sw_halt;
    logic                do_single;
    logic                do_first;
    logic                do_second;
    logic                do_halt;
    logic [WDTU_NEV-1:0] events;

    ////////////////////////////////////////////////////////////////////////////
    // Enable decode: the key alone cannot disable when the option enables
    assign enabled = cfg_wdt_enable
                   || (st.control[WDTU_KEY_HI:0] != WDTU_KEY_DISABLE);

    // Source clock: sub clock from crystal or RC, else system clock over four
    assign sub_tick = cfg_sub_from_crystal ? low_speed_crystal_osc_tick
                                           : low_speed_rc_osc_tick;
    // System clock stops in sleep and first idle, so the divide-by-four halts
    assign sys_stopped = sleep_mode || first_idle_mode;
    assign src_tick = cfg_src_sub ? sub_tick
                    : ((st.sysdiv == WDTU_SYS_DIV) && !sys_stopped);

    ////////////////////////////////////////////////////////////////////////////
    // APB access decode; single-cycle access phase, no wait states
    assign wr_acc = psel && penable && pwrite;
    assign rd_acc = psel && !penable && !pwrite;

    assign sw_single = wr_acc && (paddr == WDTU_CMD_OFS) && pwdata[WDTU_CMD_SINGLE];
    assign sw_first  = wr_acc && (paddr == WDTU_CMD_OFS) && pwdata[WDTU_CMD_FIRST];
    assign sw_second = wr_acc && (paddr == WDTU_CMD_OFS) && pwdata[WDTU_CMD_SECOND];
    assign sw_halt   = wr_acc && (paddr == WDTU_CMD_OFS) && pwdata[WDTU_CMD_HALT];

    // Clear instructions count only while enabled; disabled means no-operation, but halt still sets the power-down flag
    assign do_single = enabled && !cfg_pair_clear
                     && (single_clear_instr || sw_single);
    assign do_first  = enabled && cfg_pair_clear
                     && (first_pair_clear_instr || sw_first);
    assign do_second = enabled && cfg_pair_clear
                     && (second_pair_clear_instr || sw_second);
    assign do_halt   = halt_instr || sw_halt;

    // Pair clears only restart the count when they alternate
    assign pair_ok = (do_first && st.pair == WDTU_EXPECT_FIRST)
                  || (do_second && st.pair == WDTU_EXPECT_SECOND);
    assign any_clear = do_single || pair_ok;
    // Disabled watchdog holds its count at zero
    assign div_clear = any_clear || (do_halt && enabled) || !external_reset_pin_n
                     || !enabled;

    wdtu_divider #(
        .W(WDTU_DIV_W)
    ) u_div (
        .pclk      (pclk),
        .presetn   (presetn),
        .tick      (src_tick && enabled),
        .clear     (div_clear),
        .period_sel(st.control[WDTU_PER_HI:WDTU_PER_LO]),
        .overflow  (overflow)
    );

    // Overflow kind depends on power mode at the time
    assign events[WDTU_EV_NORMAL] = overflow && !(sleep_mode || idle_mode);
    assign events[WDTU_EV_SLEEP]  = overflow && (sleep_mode || idle_mode);

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        next_st = st;
        next_st.dev_rst = 1'b0;
        next_st.pcsp_rst = 1'b0;
        // System clock prescaler; a clear of the watchdog restarts it too
        if (div_clear) begin
            next_st.sysdiv = '0;
        end else if (!sys_stopped) begin
            next_st.sysdiv = st.sysdiv + 1'b1;
        end
        // Pair sequencing state
        if (!external_reset_pin_n) begin
            next_st.pair = WDTU_EXPECT_FIRST;
        end else if (pair_ok && do_first) begin
            next_st.pair = WDTU_EXPECT_SECOND;
        end else if (pair_ok && do_second) begin
            next_st.pair = WDTU_EXPECT_FIRST;
        end
        // Control register write
        if (wr_acc && paddr == WDTU_CONTROL_OFS) begin
            next_st.control = pwdata[7:0];
        end
        // Power-down flag: halt sets, clear instruction clears
        if (do_halt) begin
            next_st.pd_flag = 1'b1;
            next_st.to_flag = 1'b0;
        end else if (do_single || do_first || do_second) begin
            next_st.pd_flag = 1'b0;
            next_st.to_flag = 1'b0;
        end
        // Time-out: set wins over any clear
        if (events[WDTU_EV_NORMAL]) begin
            next_st.to_flag = 1'b1;
            next_st.dev_rst = 1'b1;
        end
        if (events[WDTU_EV_SLEEP]) begin
            next_st.to_flag = 1'b1;
            next_st.pcsp_rst = 1'b1;
        end
        // Interrupt status: write one to clear, new event wins
        if (wr_acc && paddr == WDTU_IRQ_ST_OFS) begin
            next_st.irq_st = st.irq_st & ~pwdata[WDTU_NEV-1:0];
        end
        next_st.irq_st = next_st.irq_st | events;
        if (wr_acc && paddr == WDTU_IRQ_MSK_OFS) begin
            next_st.irq_msk = pwdata[WDTU_NEV-1:0];
        end
        // Read data captured in setup phase, presented in access phase
        if (rd_acc) begin
            case (paddr)
                WDTU_CONTROL_OFS: next_st.rdata = {24'h000000, st.control};
                WDTU_STATUS_OFS:  next_st.rdata = {29'h00000000, enabled,
                                                   st.pd_flag, st.to_flag};
                WDTU_IRQ_ST_OFS:  next_st.rdata = {30'h00000000, st.irq_st};
                WDTU_IRQ_MSK_OFS: next_st.rdata = {30'h00000000, st.irq_msk};
                default:          next_st.rdata = 32'h00000000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register; power-on values
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st.control  <= WDTU_CONTROL_RST;
            st.to_flag  <= 1'b0;
            st.pd_flag  <= 1'b0;
            st.pair     <= WDTU_EXPECT_FIRST;
            st.sysdiv   <= '0;
            st.dev_rst  <= 1'b0;
            st.pcsp_rst <= 1'b0;
            st.irq_st   <= '0;
            st.irq_msk  <= '0;
            st.rdata    <= 32'h00000000;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign prdata  = st.rdata;
    assign pready  = 1'b1;
    // Unmapped addresses answer with an error, reads return zero
    assign pslverr = psel && penable && !((paddr == WDTU_CONTROL_OFS)
                  || (paddr == WDTU_STATUS_OFS) || (paddr == WDTU_IRQ_ST_OFS)
                  || (paddr == WDTU_IRQ_MSK_OFS)
                  || (pwrite && paddr == WDTU_CMD_OFS));
    assign idle_sysclk_keep_on = st.control[WDTU_IDLE_BIT];
    assign device_reset        = st.dev_rst;
    assign pc_sp_reset         = st.pcsp_rst;
    assign timeout_flag        = st.to_flag;
    assign power_down_flag     = st.pd_flag;
    assign irq                 = |(st.irq_st & st.irq_msk);
endmodule

//--- wdtu_top_sva.sv
// Checker for the watchdog unit: port relations of wdtu_top.
// Assumes one pclk domain and the asynchronous active-low presetn.
module wdtu_top_sva
    import wdtu_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        cfg_wdt_enable,
    input wire logic        cfg_pair_clear,
    input wire logic        single_clear_instr,
    input wire logic        halt_instr,
    input wire logic        sleep_mode,
    input wire logic        idle_mode,
    input wire logic        idle_sysclk_keep_on,
    input wire logic        device_reset,
    input wire logic        pc_sp_reset,
    input wire logic        timeout_flag,
    input wire logic        power_down_flag
);
    ////////////////////////////////////////////////////////////////////////
    // Shadow of the enable key, so the checker knows when the unit is off
    logic [3:0] key;
    logic       wr_ctl;
    logic       off;
    assign wr_ctl = psel && penable && pwrite && (paddr == WDTU_CONTROL_OFS);
    assign off    = !cfg_wdt_enable && (key == WDTU_KEY_DISABLE);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            key <= WDTU_KEY_DISABLE;
        end else if (wr_ctl) begin
            key <= pwdata[3:0];
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Relations; all sampled on pclk, quiet during reset
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    a_ovf_sets_flag: assert property (device_reset |-> timeout_flag)
        else $error("full reset without time-out flag");
    a_sleep_partial: assert property (
        pc_sp_reset |-> timeout_flag && $past(sleep_mode || idle_mode))
        else $error("partial reset outside low-power mode or without flag");
    a_full_pulse: assert property (
        device_reset |-> !$past(sleep_mode || idle_mode) ##1 !device_reset)
        else $error("full reset in low-power mode or longer than one cycle");
    a_idle_bit: assert property (wr_ctl |=> idle_sysclk_keep_on == $past(pwdata[7]))
        else $error("idle clock bit does not follow the write");
    a_off_quiet: assert property (
        off && $past(off) && $past(off, 2) |-> !device_reset && !pc_sp_reset)
        else $error("reset raised while disabled");
    a_halt_pdf: assert property (halt_instr && !off |=> power_down_flag)
        else $error("halt did not set power-down flag");
    a_clear_pdf: assert property (
        single_clear_instr && !cfg_pair_clear && !off && !halt_instr
        && !(psel && penable && pwrite && paddr == WDTU_CMD_OFS) |=> !power_down_flag)
        else $error("clear did not drop power-down flag");
    a_off_nop: assert property (
        single_clear_instr && off && power_down_flag |=> power_down_flag)
        else $error("clear acted while disabled");
endmodule

bind wdtu_top wdtu_top_sva u_sva (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .cfg_wdt_enable, .cfg_pair_clear, .single_clear_instr, .halt_instr, .sleep_mode,
    .idle_mode, .idle_sysclk_keep_on, .device_reset, .pc_sp_reset, .timeout_flag,
    .power_down_flag);
